// file: verilog/ftbs_sram.sv
// Memory end: 256K x 36 flow-through burst SRAM with four 9-bit lanes.
// Assumes pins are synchronous to ref_clk; the host keeps its own timing.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Load address when load, clock enable, selects true
// - Two low address bits seed burst counter
// - Each 9-bit lane has own write enable
// - Host gives lane enables on write beats
// - Lane enables ignored when read sampled
// - Enabled lanes stored one cycle after address
// - Host may tie lane enables low
// - Clock enable high freezes everything
// - Host keeps clock enable low to act
// - Loaded direction holds for whole burst
// - Data moves one cycle after address
// - Output enable, snooze, order act asynchronously
// - Load with false select starts deselect
// - Data bus floats one cycle after deselect
// - Advance steps counter, ignores address, direction
// - Order pin high interleaved, low linear
// - Drive data only while output enable low
// - One load yields four data beats
module ftbs_sram (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	ftbs_if.dev       pins
);
	typedef struct packed {
		ftbs_pkg::ftbs_burst_e burst;
		logic [17:0]           base;
		logic [1:0]            beat;
		logic                  pend_valid;
		logic                  pend_write;
		logic [17:0]           pend_addr;
		logic [3:0]            pend_lane_n;
		logic [35:0]           rdata;
		logic                  drive;
	} ftbs_state_s;

	ftbs_state_s st_reg;
	ftbs_state_s st_next;

	// Full depth kept; costly in simulation, though few words are used
	logic [35:0] mem [ftbs_pkg::DEPTH];

	logic        act;
	logic        selected;
	logic        retire_wr;
	logic [17:0] load_addr;
	logic [1:0]  step_beat;
	logic [1:0]  step_low;
	logic [17:0] step_addr;

	// A frozen edge never happened, so nothing moves
	assign act = ~pins.clk_en_n;
	assign selected = ~pins.chip_select_n & ~pins.second_select_n
		& pins.second_select;
	assign load_addr = {pins.addr_upper_bits, pins.addr_bit1,
		pins.addr_bit0};
	// Write data is on the bus one cycle after its address
	assign retire_wr = act & st_reg.pend_valid & st_reg.pend_write;
	assign step_beat = st_reg.beat + 2'h1;
	// Order pin is read live; it must stay static during a burst
	assign step_low = pins.burst_order
		? (st_reg.base[1:0] ^ step_beat)
		: (st_reg.base[1:0] + step_beat);
	assign step_addr = {st_reg.base[17:2], step_low};

	// Read port with bypass of the write retiring at this same edge
	function automatic logic [35:0] ftbs_read(input logic [17:0] a);
		logic [35:0] w;
		w = mem[a];
		if (retire_wr && st_reg.pend_addr == a)
		begin
			for (int i = 0; i < ftbs_pkg::LANES; i++)
			begin
				if (!st_reg.pend_lane_n[i])
				begin
					w[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W] =
						pins.dq[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W];
				end
			end
		end
		return w;
	endfunction : ftbs_read

	always_comb
	begin
		st_next = st_reg;
		if (act)
		begin
			// Each data phase lasts one cycle
			st_next.pend_valid = 1'b0;
			st_next.drive = 1'b0;
			st_next.pend_lane_n = ftbs_pkg::LANE_OFF;
			if (!pins.burst_step_or_load)
			begin
				if (selected)
				begin
					// New access: direction fixed for all its beats
					st_next.burst = pins.write_n ? ftbs_pkg::FTBS_READ
						: ftbs_pkg::FTBS_WRITE;
					st_next.base = load_addr;
					st_next.beat = ftbs_pkg::BEAT_0;
					st_next.pend_valid = 1'b1;
					st_next.pend_write = ~pins.write_n;
					st_next.pend_addr = load_addr;
					st_next.pend_lane_n = pins.write_n
						? ftbs_pkg::LANE_OFF
						: pins.lane_write_en_n;
					st_next.drive = pins.write_n;
					if (pins.write_n)
					begin
						st_next.rdata = ftbs_read(load_addr);
					end
				end
				else
				begin
					// Deselect stops the burst; pending data still retires
					st_next.burst = ftbs_pkg::FTBS_IDLE;
				end
			end
			else
			begin
				case (st_reg.burst)
				ftbs_pkg::FTBS_READ,
				ftbs_pkg::FTBS_WRITE:
				begin
					if (st_reg.beat == ftbs_pkg::BEAT_LAST)
					begin
						// Fourth advance ends the burst, no transfer
						st_next.burst = ftbs_pkg::FTBS_IDLE;
					end
					else
					begin
						// External address and direction ignored here
						st_next.beat = step_beat;
						st_next.pend_valid = 1'b1;
						st_next.pend_write =
							st_reg.burst == ftbs_pkg::FTBS_WRITE;
						st_next.pend_addr = step_addr;
						st_next.pend_lane_n =
							st_reg.burst == ftbs_pkg::FTBS_WRITE
							? pins.lane_write_en_n
							: ftbs_pkg::LANE_OFF;
						st_next.drive =
							st_reg.burst == ftbs_pkg::FTBS_READ;
						if (st_reg.burst == ftbs_pkg::FTBS_READ)
						begin
							st_next.rdata = ftbs_read(step_addr);
						end
					end
				end
				default:
				begin
					st_next.burst = ftbs_pkg::FTBS_IDLE;
				end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg <= '{burst: ftbs_pkg::FTBS_IDLE,
				base: ftbs_pkg::ADDR_RST,
				beat: ftbs_pkg::BEAT_0,
				pend_valid: 1'b0,
				pend_write: 1'b0,
				pend_addr: ftbs_pkg::ADDR_RST,
				pend_lane_n: ftbs_pkg::LANE_OFF,
				rdata: ftbs_pkg::DATA_RST,
				drive: 1'b0};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Array has no reset; contents are undefined until written
	always_ff @(posedge ref_clk)
	begin
		if (retire_wr)
		begin
			for (int i = 0; i < ftbs_pkg::LANES; i++)
			begin
				if (!st_reg.pend_lane_n[i])
				begin
					mem[st_reg.pend_addr][i*ftbs_pkg::LANE_W +:
						ftbs_pkg::LANE_W] <=
						pins.dq[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W];
				end
			end
		end
	end

	assign pins.dq_dev = st_reg.rdata;
	// Enable gating is asynchronous by nature, so not a pure flop
	assign pins.dq_dev_oe = st_reg.drive & ~pins.output_enable_n
		& ~pins.snooze_input;
endmodule : ftbs_sram
`default_nettype wire

// file: verilog/ftbs_pkg.sv
// Shared constants and types for the flow-through burst SRAM port.
// Assumes one 20 MHz clock shared by the memory and its controller.
package ftbs_pkg;
	localparam int unsigned LANE_W   = 9;
	localparam int unsigned LANES    = 4;
	localparam int unsigned DATA_W   = 36;
	localparam int unsigned ADDR_W   = 18;
	localparam int unsigned UPPER_W  = 16;
	localparam int unsigned DEPTH    = 262144;
	localparam int unsigned CLK_NS   = 50;
	localparam logic [1:0]  BEAT_0    = 2'h0;
	localparam logic [1:0]  BEAT_LAST = 2'h3;
	localparam logic [3:0]  LANE_OFF  = 4'hF;
	localparam logic [35:0] DATA_RST  = 36'h0;
	localparam logic [17:0] ADDR_RST  = 18'h0;

	// Gray path: idle -> read burst -> write burst
	typedef enum logic [1:0] {
		FTBS_IDLE  = 2'h0,
		FTBS_READ  = 2'h1,
		FTBS_WRITE = 2'h3
	} ftbs_burst_e;
endpackage : ftbs_pkg

// file: verilog/ftbs_if.sv
// Pin bundle between the SRAM port and its host controller.
// Assumes the testbench drives ref_clk; the data bus is resolved here.
`timescale 1ns/10ps
`default_nettype none
interface ftbs_if;
	logic        clk_en_n;
	logic        burst_step_or_load;
	logic        write_n;
	logic        chip_select_n;
	logic        second_select_n;
	logic        second_select;
	logic        output_enable_n;
	logic        burst_order;
	logic        snooze_input;
	logic [15:0] addr_upper_bits;
	logic        addr_bit1;
	logic        addr_bit0;
	logic [3:0]  lane_write_en_n;
	logic [35:0] dq_dev;
	logic        dq_dev_oe;
	logic [35:0] dq_host;
	logic        dq_host_oe;
	logic [35:0] dq;

	// Bus level; device wins if both drive, which the timing forbids
	assign dq = dq_dev_oe ? dq_dev : dq_host;

	modport dev (
		input  clk_en_n, burst_step_or_load, write_n, chip_select_n,
		input  second_select_n, second_select, output_enable_n,
		input  burst_order, snooze_input, addr_upper_bits, addr_bit1,
		input  addr_bit0, lane_write_en_n, dq,
		output dq_dev, dq_dev_oe
	);
	modport host (
		output clk_en_n, burst_step_or_load, write_n, chip_select_n,
		output second_select_n, second_select, output_enable_n,
		output burst_order, snooze_input, addr_upper_bits, addr_bit1,
		output addr_bit0, lane_write_en_n, dq_host, dq_host_oe,
		input  dq
	);
endinterface : ftbs_if
`default_nettype wire

// file: verilog/ftbs_host.sv
// Controller end: turns user commands into SRAM pin cycles.
// Assumes the user keeps burst direction consistent across beats.
`timescale 1ns/10ps
`default_nettype none
module ftbs_host (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	ftbs_if.host             pins,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_load,
	input  wire logic        cmd_write,
	input  wire logic [17:0] cmd_addr,
	input  wire logic [35:0] cmd_wdata,
	input  wire logic [3:0]  cmd_lane_en_n,
	input  wire logic        cmd_hold,
	input  wire logic        order_interleave,
	output logic             rsp_valid,
	output logic [35:0]      rsp_data
);
	typedef struct packed {
		logic        clk_en_n;
		logic        step;
		logic        write_n;
		logic        cs_n;
		logic        order;
		logic [17:0] addr;
		logic [3:0]  lane_n;
		logic        s1_valid;
		logic        s1_write;
		logic [35:0] s1_wdata;
		logic        d_valid;
		logic        d_write;
		logic [35:0] d_wdata;
		logic        rsp_valid;
		logic [35:0] rsp_data;
		logic        burst;
		logic [1:0]  beat;
	} ftbs_host_s;

	ftbs_host_s h_reg;
	ftbs_host_s h_next;

	always_comb
	begin
		h_next = h_reg;
		h_next.rsp_valid = 1'b0;
		h_next.order = order_interleave;
		// Pipeline moves only on edges the memory also honours
		if (!h_reg.clk_en_n)
		begin
			h_next.d_valid = h_reg.s1_valid;
			h_next.d_write = h_reg.s1_write;
			h_next.d_wdata = h_reg.s1_wdata;
			if (h_reg.d_valid && !h_reg.d_write)
			begin
				h_next.rsp_valid = 1'b1;
				h_next.rsp_data = pins.dq;
			end
		end
		h_next.clk_en_n = cmd_hold;
		if (!cmd_hold)
		begin
			h_next.s1_valid = cmd_valid;
			h_next.s1_write = cmd_write;
			h_next.s1_wdata = cmd_wdata;
			h_next.lane_n = cmd_write ? cmd_lane_en_n
				: ftbs_pkg::LANE_OFF;
			if (!cmd_valid)
			begin
				h_next.step = 1'b0;
				h_next.cs_n = 1'b1;
				h_next.burst = 1'b0;
			end
			else
			begin
				h_next.step = ~cmd_load;
				h_next.cs_n = 1'b0;
				h_next.write_n = ~cmd_write;
				h_next.addr = cmd_addr;
				if (cmd_load)
				begin
					h_next.burst = 1'b1;
					h_next.beat = ftbs_pkg::BEAT_0;
				end
				else if (h_reg.burst && h_reg.beat != ftbs_pkg::BEAT_LAST)
				begin
					h_next.beat = h_reg.beat + 2'h1;
				end
				else
				begin
					// Memory drops this advance, so no data beat follows
					h_next.burst = 1'b0;
					h_next.s1_valid = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			h_reg <= '{clk_en_n: 1'b0, step: 1'b0, write_n: 1'b1,
				cs_n: 1'b1, order: 1'b1, addr: ftbs_pkg::ADDR_RST,
				lane_n: ftbs_pkg::LANE_OFF, s1_valid: 1'b0,
				s1_write: 1'b0, s1_wdata: ftbs_pkg::DATA_RST,
				d_valid: 1'b0, d_write: 1'b0,
				burst: 1'b0, beat: ftbs_pkg::BEAT_0,
				d_wdata: ftbs_pkg::DATA_RST, rsp_valid: 1'b0,
				rsp_data: ftbs_pkg::DATA_RST};
		end
		else
		begin
			h_reg <= h_next;
		end
	end

	assign pins.clk_en_n = h_reg.clk_en_n;
	assign pins.burst_step_or_load = h_reg.step;
	assign pins.write_n = h_reg.write_n;
	assign pins.chip_select_n = h_reg.cs_n;
	assign pins.second_select_n = 1'b0;
	assign pins.second_select = 1'b1;
	assign pins.output_enable_n = 1'b0;
	assign pins.burst_order = h_reg.order;
	assign pins.snooze_input = 1'b0;
	assign pins.addr_upper_bits = h_reg.addr[17:2];
	assign pins.addr_bit1 = h_reg.addr[1];
	assign pins.addr_bit0 = h_reg.addr[0];
	assign pins.lane_write_en_n = h_reg.lane_n;
	assign pins.dq_host = h_reg.d_wdata;
	assign pins.dq_host_oe = h_reg.d_valid & h_reg.d_write;
	assign rsp_valid = h_reg.rsp_valid;
	assign rsp_data = h_reg.rsp_data;
endmodule : ftbs_host
`default_nettype wire

// file: testbench/ftbs_props.sv
// Pin link checks between the SRAM port and its host controller.
// Assumes plain copies of the shared interface signals.
`timescale 1ns/10ps
`default_nettype none
module ftbs_props (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        clk_en_n,
	input wire logic        burst_step_or_load,
	input wire logic        write_n,
	input wire logic        chip_select_n,
	input wire logic        second_select_n,
	input wire logic        second_select,
	input wire logic [35:0] dq_dev,
	input wire logic        dq_dev_oe,
	input wire logic        dq_host_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	logic sel;
	logic go;
	logic adv;
	assign sel = !chip_select_n && !second_select_n && second_select;
	assign go = !clk_en_n && !burst_step_or_load;
	assign adv = !clk_en_n && burst_step_or_load;
	sequence ld_rd;
		go && sel && write_n;
	endsequence
	sequence ld_wr;
		go && sel && !write_n;
	endsequence
	a_read_drives: assert property (ld_rd |=> dq_dev_oe)
		else $error("no drive after read load");
	a_write_floats: assert property (ld_wr |=> !dq_dev_oe)
		else $error("device drives on write beat");
	a_host_writes: assert property (ld_wr |=> dq_host_oe)
		else $error("host silent on write beat");
	a_host_quiet: assert property (ld_rd |=> !dq_host_oe)
		else $error("host drives on read beat");
	a_desel_floats: assert property (go && !sel |=> !dq_dev_oe)
		else $error("bus driven after deselect");
	a_hold_freezes: assert property (clk_en_n |=>
		$stable(dq_dev) && $stable(dq_dev_oe))
		else $error("output moved on held edge");
	a_burst_four: assert property (ld_rd ##1 adv [*3] |=> dq_dev_oe)
		else $error("burst shorter than four");
	a_burst_ends: assert property (ld_rd ##1 adv [*4] |=> !dq_dev_oe)
		else $error("fifth beat driven");
	a_dir_kept: assert property (ld_wr ##1 adv |=>
		dq_host_oe && !dq_dev_oe)
		else $error("direction lost on advance");
	a_desel_stops: assert property (
		go && !sel ##1 adv |=> !dq_dev_oe)
		else $error("advance after deselect drove bus");
	cover property (ld_rd ##1 adv [*3]);
	cover property (ld_wr ##1 adv [*3]);
	cover property (clk_en_n ##1 adv);
endmodule : ftbs_props
`default_nettype wire

// file: testbench/tb_top.sv
// Top bench: host and SRAM ends joined by one interface.
// Assumes one clock; words are checked at the host user side.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        ref_clk;
	logic        rst_b;
	logic        cmd_valid;
	logic        cmd_load;
	logic        cmd_write;
	logic        cmd_hold;
	logic        order_interleave;
	logic        rsp_valid;
	logic [17:0] cmd_addr;
	logic [35:0] cmd_wdata;
	logic [35:0] rsp_data;
	logic [3:0]  cmd_lane_en_n;
	logic [35:0] rq[$];
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	ftbs_if pins();
	ftbs_sram i_ftbs_sram (.ref_clk(ref_clk), .rst_b(rst_b), .pins(pins));
	ftbs_host i_ftbs_host (.ref_clk(ref_clk), .rst_b(rst_b), .pins(pins),
		.cmd_valid(cmd_valid), .cmd_load(cmd_load), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_lane_en_n(cmd_lane_en_n), .cmd_hold(cmd_hold),
		.order_interleave(order_interleave), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data));
	ftbs_props i_ftbs_props (.ref_clk(ref_clk), .rst_b(rst_b),
		.clk_en_n(pins.clk_en_n), .burst_step_or_load(pins.burst_step_or_load),
		.write_n(pins.write_n), .chip_select_n(pins.chip_select_n),
		.second_select_n(pins.second_select_n),
		.second_select(pins.second_select), .dq_dev(pins.dq_dev),
		.dq_dev_oe(pins.dq_dev_oe), .dq_host_oe(pins.dq_host_oe));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Negedge capture avoids racing the response flops
	always @(negedge ref_clk)
		if (rsp_valid === 1'b1)
			rq.push_back(rsp_data);
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic cmd(input logic v, ld, wr, h, input logic [17:0] a,
		input logic [35:0] d, input logic [3:0] l);
		cmd_valid = v;
		cmd_load = ld;
		cmd_write = wr;
		cmd_hold = h;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_lane_en_n = l;
		@(posedge ref_clk);
		#2;
	endtask : cmd
	task automatic idle(input int n);
		repeat (n) cmd(1'b0, 1'b1, 1'b0, 1'b0, 18'h0, 36'h0, 4'hF);
	endtask : idle
	task automatic check_word(input logic [35:0] e);
		logic [35:0] g;
		g = rq.size() ? rq.pop_front() : 36'hF0F0F0F0F;
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask : check_word
	task automatic check_count(input int unsigned g, e);
		samples_checked++;
		if (g != e)
		begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask : check_count
	// Load plus four advances; the last must be dropped
	task automatic t_read(input logic o, input logic [17:0] a,
		input logic [35:0] e0, e1, e2, e3);
		order_interleave = o;
		idle(2);
		cmd(1'b1, 1'b1, 1'b0, 1'b0, a, 36'h0, 4'h0);
		repeat (4) cmd(1'b1, 1'b0, 1'b0, 1'b0, 18'h3FFFF, 36'h0, 4'h0);
		idle(5);
		check_word(e0);
		check_word(e1);
		check_word(e2);
		check_word(e3);
		check_count(rq.size(), 0);
	endtask : t_read
	// Deselect stops the burst; a later advance gives nothing
	task automatic t_desel;
		cmd(1'b1, 1'b1, 1'b0, 1'b0, 18'h00105, 36'h0, 4'hF);
		idle(1);
		cmd(1'b1, 1'b0, 1'b0, 1'b0, 18'h0, 36'h0, 4'hF);
		idle(4);
		check_word(36'h111111111);
		check_count(rq.size(), 0);
	endtask : t_desel
	task automatic t_lin_write;
		order_interleave = 1'b0;
		idle(2);
		cmd(1'b1, 1'b1, 1'b1, 1'b0, 18'h00105, 36'h111111111, 4'h0);
		cmd(1'b1, 1'b0, 1'b1, 1'b0, 18'h0, 36'h222222222, 4'h0);
		cmd(1'b1, 1'b0, 1'b1, 1'b0, 18'h0, 36'h333333333, 4'h0);
		cmd(1'b1, 1'b0, 1'b1, 1'b0, 18'h0, 36'h444444444, 4'h0);
		idle(3);
	endtask : t_lin_write
	// Lanes b and d kept; back to back reads follow
	task automatic t_lanes;
		logic [35:0] m;
		m = 36'hFF803FE00;
		cmd(1'b1, 1'b1, 1'b1, 1'b0, 18'h00104, 36'hFFFFFFFFF, 4'hA);
		cmd(1'b1, 1'b1, 1'b0, 1'b0, 18'h00104, 36'h0, 4'h0);
		cmd(1'b1, 1'b1, 1'b0, 1'b0, 18'h00104, 36'h0, 4'h0);
		idle(5);
		check_word((36'h444444444 & m) | ~m);
		check_word((36'h444444444 & m) | ~m);
	endtask : t_lanes
	// Held edges inside a burst only delay the beats
	task automatic t_hold;
		order_interleave = 1'b0;
		idle(2);
		cmd(1'b1, 1'b1, 1'b0, 1'b0, 18'h00105, 36'h0, 4'hF);
		cmd(1'b1, 1'b0, 1'b0, 1'b1, 18'h0, 36'h0, 4'hF);
		cmd(1'b1, 1'b0, 1'b0, 1'b0, 18'h0, 36'h0, 4'hF);
		repeat (2) cmd(1'b1, 1'b0, 1'b0, 1'b1, 18'h0, 36'h0, 4'hF);
		repeat (2) cmd(1'b1, 1'b0, 1'b0, 1'b0, 18'h0, 36'h0, 4'hF);
		idle(6);
		check_word(36'h111111111);
		check_word(36'h222222222);
		check_word(36'h333333333);
		check_word(36'h444444444);
	endtask : t_hold
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		rst_b = 1'b0;
		order_interleave = 1'b1;
		cmd_valid = 1'b0;
		cmd_load = 1'b1;
		cmd_write = 1'b0;
		cmd_hold = 1'b0;
		cmd_addr = 18'h0;
		cmd_wdata = 36'h0;
		cmd_lane_en_n = 4'hF;
		repeat (3) @(posedge ref_clk);
		#2;
		rst_b = 1'b1;
		t_lin_write();
		t_read(1'b0, 18'h00107, 36'h333333333, 36'h444444444,
			36'h111111111, 36'h222222222);
		t_read(1'b1, 18'h00106, 36'h222222222, 36'h333333333,
			36'h444444444, 36'h111111111);
		t_hold();
		t_lanes();
		t_desel();
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
